/* core/ifd_decoder.v */
// instruction format decoder with wishbone register slave and storage fetch port
// assumes storage answers memRd with a one-cycle memAck on the same clock
//
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "ifd_defs.vh"
module ifd_decoder #(
	parameter WAW = 15,
	parameter CAW = 17
) (
	// clock and reset
	input wire clock,
	input wire sys_rst,
	// wishbone slave
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [5:0] adr_i,
	input wire [31:0] dat_i,
	input wire [3:0] sel_i,
	output reg [31:0] dat_o,
	output reg ack_o,
	// core storage fetch port
	output reg memRd,
	output reg [WAW-1:0] memAddr,
	input wire [23:0] memData,
	input wire memAck,
	// execution control
	output reg cpuDispatch,
	output reg business_data_unitStart,
	output reg opTerminate,
	// io control
	input wire xferDone,
	output reg ioIrqReq,
	output reg wordCountCtl,
	output reg [2:0] io_channel_select
);
	localparam S_IDLE = 4'h1;
	localparam S_FETCH = 4'h2;
	localparam S_CHASE = 4'h4;
	localparam S_DONE = 4'h8;
	reg [3:0] state_reg;
	reg [1:0] fmt_reg;
	reg dc8_reg;
	reg done_reg;
	reg term_reg;
	reg [WAW-1:0] pAddr_reg;
	reg [WAW-1:0] idx1_reg;
	reg [WAW-1:0] idx2_reg;
	reg [WAW-1:0] idx3_reg;
	reg [23:0] instr0_reg;
	reg [23:0] instr1_reg;
	reg [23:0] instr2_reg;
	reg [1:0] wordCnt_reg;
	reg chainA_reg;
	reg [1:0] chainB_reg;
	reg [WAW-1:0] chainM_reg;
	reg [CAW-1:0] effAddr_reg;
	reg [CAW-1:0] fieldA_reg;
	reg [CAW-1:0] fieldC_reg;
	reg [7:0] testChar_reg;
	reg delimHit_reg;
	reg scanHit_reg;
	reg [WAW+1:0] convWa_reg;
	reg [CAW-1:0] convCa_reg;
	reg [31:0] rdData_next;
	wire busReq = cyc_i & stb_i;
	wire wrDo = busReq & we_i & ack_o;
	wire [CAW-1:0] convCharOut;
	wire [WAW-1:0] convWordOut;
	wire [1:0] convPosOut;
	// designator b selects one of three index registers, 0 adds nothing
	function [WAW-1:0] idxSel;
		input [1:0] b;
		input [WAW-1:0] i1;
		input [WAW-1:0] i2;
		input [WAW-1:0] i3;
		begin
			case (b)
			2'h1: idxSel = i1;
			2'h2: idxSel = i2;
			2'h3: idxSel = i3;
			default: idxSel = {WAW{1'b0}};
			endcase
		end
	endfunction
	// business field flag: 1 and 3 share register 1
	function [WAW-1:0] bduSel;
		input [1:0] f;
		input [WAW-1:0] i1;
		input [WAW-1:0] i2;
		begin
			case (f)
			2'h1, 2'h3: bduSel = i1;
			2'h2: bduSel = i2;
			default: bduSel = {WAW{1'b0}};
			endcase
		end
	endfunction
	// byte-lane merge for writes, unselected lanes keep the old value
	wire [CAW-1:0] wrOld = (adr_i == `IFD_OFS_CONVWA) ? convWa_reg : (adr_i == `IFD_OFS_CONVCA) ? convCa_reg :
		(adr_i == `IFD_OFS_IDX1) ? {2'h0, idx1_reg} : (adr_i == `IFD_OFS_IDX2) ? {2'h0, idx2_reg} :
		(adr_i == `IFD_OFS_IDX3) ? {2'h0, idx3_reg} : {2'h0, pAddr_reg};
	wire [31:0] laneMask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
	wire [31:0] wrMerge = (dat_i & laneMask) | ({15'h0000, wrOld} & ~laneMask);
	ifd_addr_conv #(
		.WAW(WAW)
	) uConv (
		.wordAddrIn(convWa_reg[WAW-1:0]),
		.charPosIn(convWa_reg[WAW+1:WAW]),
		.charAddrIn(convCa_reg),
		.charAddrOut(convCharOut),
		.wordAddrOut(convWordOut),
		.charPosOut(convPosOut)
	);
	// read mux
	always @* begin
		rdData_next = 32'h00000000;
		case (adr_i)
		`IFD_OFS_CTRL: begin
			rdData_next[`IFD_CTRL_FMT_HI:`IFD_CTRL_FMT_LO] = fmt_reg;
			rdData_next[`IFD_CTRL_DC8] = dc8_reg;
			rdData_next[`IFD_CTRL_BUSY] = ~state_reg[0];
			rdData_next[`IFD_CTRL_DONE] = done_reg;
			rdData_next[`IFD_CTRL_TERM] = term_reg;
			rdData_next[`IFD_CTRL_DHIT] = delimHit_reg;
			rdData_next[`IFD_CTRL_SHIT] = scanHit_reg;
		end
		`IFD_OFS_PADDR: rdData_next[WAW-1:0] = pAddr_reg;
		`IFD_OFS_IDX1: rdData_next[WAW-1:0] = idx1_reg;
		`IFD_OFS_IDX2: rdData_next[WAW-1:0] = idx2_reg;
		`IFD_OFS_IDX3: rdData_next[WAW-1:0] = idx3_reg;
		`IFD_OFS_WORD0: rdData_next[23:0] = instr0_reg;
		`IFD_OFS_EADDR: rdData_next[CAW-1:0] = effAddr_reg;
		`IFD_OFS_FIELDS: begin
			rdData_next[`IFD_F_A] = instr0_reg[`IFD_W_A];
			rdData_next[`IFD_F_B_LO +: 2] = (fmt_reg == `IFD_FMT_CHAR) ?
				instr0_reg[`IFD_C_B_HI:`IFD_C_B_LO] : instr0_reg[`IFD_W_B_HI:`IFD_W_B_LO];
			rdData_next[`IFD_F_V_LO +: 6] = instr0_reg[5:0];
			rdData_next[`IFD_F_W_LO +: 7] = instr0_reg[6:0];
			rdData_next[`IFD_F_CH_LO +: 3] = instr0_reg[`IFD_IO_CH_HI:`IFD_IO_CH_LO];
			rdData_next[`IFD_F_INT] = instr0_reg[`IFD_IO_INT];
			rdData_next[`IFD_F_G] = instr0_reg[`IFD_IO_G];
			rdData_next[`IFD_F_FA_LO +: 2] = instr1_reg[`IFD_BUS_F_HI:`IFD_BUS_F_LO];
			rdData_next[`IFD_F_FC_LO +: 2] = instr2_reg[`IFD_BUS_F_HI:`IFD_BUS_F_LO];
		end
		`IFD_OFS_FLDA: rdData_next[CAW-1:0] = fieldA_reg;
		`IFD_OFS_FLDC: rdData_next[CAW-1:0] = fieldC_reg;
		`IFD_OFS_CHTEST: rdData_next[7:0] = testChar_reg;
		`IFD_OFS_CONVWA: rdData_next[CAW-1:0] = convCharOut;
		`IFD_OFS_CONVCA: rdData_next[WAW+1:0] = {convPosOut, convWordOut};
		`IFD_OFS_CHARS: begin
			rdData_next[7:0] = instr0_reg[`IFD_BUS_DC_HI:`IFD_BUS_DC_LO];
			rdData_next[13:8] = instr0_reg[`IFD_BUS_SC_HI:`IFD_BUS_SC_LO];
		end
		default: rdData_next = 32'h00000000;
		endcase
	end
	// bus handshake: answer one cycle after the request, drop after one
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end else begin
			ack_o <= busReq & ~ack_o;
			dat_o <= (busReq & ~ack_o) ? rdData_next : dat_o;
		end
	end
	// software-written registers
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			fmt_reg <= `IFD_FMT_WORD;
			dc8_reg <= 1'b0;
			pAddr_reg <= {WAW{1'b0}};
			idx1_reg <= {WAW{1'b0}};
			idx2_reg <= {WAW{1'b0}};
			idx3_reg <= {WAW{1'b0}};
			testChar_reg <= 8'h00;
			convWa_reg <= {(WAW+2){1'b0}};
			convCa_reg <= `IFD_RST_ADDR;
		end else if (wrDo) begin
			case (adr_i)
			`IFD_OFS_CTRL: if (state_reg[0] & sel_i[0]) begin
				fmt_reg <= dat_i[`IFD_CTRL_FMT_HI:`IFD_CTRL_FMT_LO];
				dc8_reg <= dat_i[`IFD_CTRL_DC8];
			end
			`IFD_OFS_PADDR: pAddr_reg <= wrMerge[WAW-1:0];
			`IFD_OFS_IDX1: idx1_reg <= wrMerge[WAW-1:0];
			`IFD_OFS_IDX2: idx2_reg <= wrMerge[WAW-1:0];
			`IFD_OFS_IDX3: idx3_reg <= wrMerge[WAW-1:0];
			`IFD_OFS_CHTEST: if (sel_i[0]) testChar_reg <= dat_i[7:0];
			`IFD_OFS_CONVWA: convWa_reg <= wrMerge[WAW+1:0];
			`IFD_OFS_CONVCA: convCa_reg <= wrMerge[CAW-1:0];
			default: ;
			endcase
		end
	end
	wire startReq = wrDo & (adr_i == `IFD_OFS_CTRL) & sel_i[0] & dat_i[`IFD_CTRL_START] & state_reg[0];
	wire chTestWr = wrDo & (adr_i == `IFD_OFS_CHTEST) & sel_i[0];
	wire [7:0] dcChar = instr0_reg[`IFD_BUS_DC_HI:`IFD_BUS_DC_LO];
	wire [5:0] scChar = instr0_reg[`IFD_BUS_SC_HI:`IFD_BUS_SC_LO];
	wire dcMatch = dc8_reg ? (dat_i[7:0] == dcChar) : (dat_i[5:0] == dcChar[5:0]);
	wire ioFmt = (fmt_reg == `IFD_FMT_IO);
	wire [WAW-1:0] chaseAddr = memData[WAW-1:0] +
		idxSel(memData[`IFD_W_B_HI:`IFD_W_B_LO], idx1_reg, idx2_reg, idx3_reg);
	// fetch, indirect chase and decode sequencer
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= S_IDLE;
			memRd <= 1'b0;
			memAddr <= {WAW{1'b0}};
			wordCnt_reg <= 2'h0;
			instr0_reg <= `IFD_RST_WORD;
			instr1_reg <= `IFD_RST_WORD;
			instr2_reg <= `IFD_RST_WORD;
			chainA_reg <= 1'b0;
			chainB_reg <= 2'h0;
			chainM_reg <= {WAW{1'b0}};
			effAddr_reg <= `IFD_RST_ADDR;
			fieldA_reg <= `IFD_RST_ADDR;
			fieldC_reg <= `IFD_RST_ADDR;
			done_reg <= 1'b0;
			cpuDispatch <= 1'b0;
			business_data_unitStart <= 1'b0;
		end else begin
			cpuDispatch <= 1'b0;
			business_data_unitStart <= 1'b0;
			case (state_reg)
			S_IDLE: begin
				if (startReq) begin
					done_reg <= 1'b0;
					wordCnt_reg <= 2'h0;
					memAddr <= pAddr_reg;
					memRd <= 1'b1;
					state_reg <= S_FETCH;
				end
			end
			S_FETCH: begin
				if (memAck) begin
					case (wordCnt_reg)
					2'h0: instr0_reg <= memData;
					2'h1: instr1_reg <= memData;
					default: instr2_reg <= memData;
					endcase
					if (wordCnt_reg == 2'h0) begin
						chainA_reg <= memData[`IFD_W_A];
						chainB_reg <= memData[`IFD_W_B_HI:`IFD_W_B_LO];
						chainM_reg <= memData[WAW-1:0];
					end
					if ((fmt_reg == `IFD_FMT_BUS) && (wordCnt_reg != 2'h2)) begin
						wordCnt_reg <= wordCnt_reg + 2'h1;
						memAddr <= memAddr + {{(WAW-1){1'b0}}, 1'b1};
					end else if ((fmt_reg == `IFD_FMT_WORD) && memData[`IFD_W_A]) begin
						memAddr <= chaseAddr;
						state_reg <= S_CHASE;
					end else begin
						memRd <= 1'b0;
						state_reg <= S_DONE;
					end
				end
			end
			S_CHASE: begin
				if (memAck) begin
					chainA_reg <= memData[`IFD_W_A];
					chainB_reg <= memData[`IFD_W_B_HI:`IFD_W_B_LO];
					chainM_reg <= memData[WAW-1:0];
					if (memData[`IFD_W_A]) begin
						memAddr <= chaseAddr;
					end else begin
						memRd <= 1'b0;
						state_reg <= S_DONE;
					end
				end
			end
			S_DONE: begin
				done_reg <= 1'b1;
				state_reg <= S_IDLE;
				case (fmt_reg)
				`IFD_FMT_WORD: begin
					effAddr_reg <= {2'h0, chainM_reg +
						idxSel(chainB_reg, idx1_reg, idx2_reg, idx3_reg)};
					cpuDispatch <= 1'b1;
				end
				`IFD_FMT_CHAR: begin
					effAddr_reg <= instr0_reg[CAW-1:0] + {2'h0, idxSel(
						instr0_reg[`IFD_C_B_HI:`IFD_C_B_LO], idx1_reg, idx2_reg, idx3_reg)};
					cpuDispatch <= 1'b1;
				end
				`IFD_FMT_BUS: begin
					fieldA_reg <= instr1_reg[CAW-1:0] + {2'h0, bduSel(
						instr1_reg[`IFD_BUS_F_HI:`IFD_BUS_F_LO], idx1_reg, idx2_reg)};
					fieldC_reg <= instr2_reg[CAW-1:0] + {2'h0, bduSel(
						instr2_reg[`IFD_BUS_F_HI:`IFD_BUS_F_LO], idx1_reg, idx2_reg)};
					effAddr_reg <= instr1_reg[CAW-1:0] + {2'h0, bduSel(
						instr1_reg[`IFD_BUS_F_HI:`IFD_BUS_F_LO], idx1_reg, idx2_reg)};
					business_data_unitStart <= 1'b1;
				end
				default: begin
					effAddr_reg <= {2'h0, instr0_reg[WAW-1:0]};
					cpuDispatch <= 1'b1;
				end
				endcase
			end
			default: begin
				memRd <= 1'b0;
				state_reg <= S_IDLE;
			end
			endcase
		end
	end
	// character comparison against delimiter and scan character
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			delimHit_reg <= 1'b0;
			scanHit_reg <= 1'b0;
			term_reg <= 1'b0;
			opTerminate <= 1'b0;
		end else begin
			opTerminate <= 1'b0;
			if (chTestWr) begin
				delimHit_reg <= dcMatch;
				scanHit_reg <= (dat_i[5:0] == scChar);
			end
			// set wins over the clear on start
			if (chTestWr & dcMatch & done_reg & (fmt_reg == `IFD_FMT_BUS)) begin
				term_reg <= 1'b1;
				opTerminate <= 1'b1;
			end else if (startReq) begin
				term_reg <= 1'b0;
			end
		end
	end
	// io controls from the decoded io word
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			ioIrqReq <= 1'b0;
			wordCountCtl <= 1'b0;
			io_channel_select <= 3'h0;
		end else begin
			ioIrqReq <= xferDone & ioFmt & done_reg & instr0_reg[`IFD_IO_INT];
			wordCountCtl <= ioFmt & done_reg & instr0_reg[`IFD_IO_IN] & instr0_reg[`IFD_IO_G];
			io_channel_select <= instr0_reg[`IFD_IO_CH_HI:`IFD_IO_CH_LO];
		end
	end
endmodule // ifd_decoder
`default_nettype wire

/* core/ifd_defs.vh */
// instruction format decoder: offsets, field positions, reset values
// assumes byte addressing on a 32-bit classic wishbone bus
`ifndef IFD_DEFS_VH
`define IFD_DEFS_VH

`define IFD_WORD_W 24
`define IFD_WADDR_W 15
`define IFD_CADDR_W 17

// register byte offsets
`define IFD_OFS_CTRL 6'h00
`define IFD_OFS_PADDR 6'h04
`define IFD_OFS_IDX1 6'h08
`define IFD_OFS_IDX2 6'h0C
`define IFD_OFS_IDX3 6'h10
`define IFD_OFS_WORD0 6'h14
`define IFD_OFS_EADDR 6'h18
`define IFD_OFS_FIELDS 6'h1C
`define IFD_OFS_FLDA 6'h20
`define IFD_OFS_FLDC 6'h24
`define IFD_OFS_CHTEST 6'h28
`define IFD_OFS_CONVWA 6'h2C
`define IFD_OFS_CONVCA 6'h30
`define IFD_OFS_CHARS 6'h34

// control register bits
`define IFD_CTRL_START 0
`define IFD_CTRL_FMT_LO 1
`define IFD_CTRL_FMT_HI 2
`define IFD_CTRL_DC8 3
`define IFD_CTRL_BUSY 8
`define IFD_CTRL_DONE 9
`define IFD_CTRL_TERM 10
`define IFD_CTRL_DHIT 11
`define IFD_CTRL_SHIT 12

// instruction formats
`define IFD_FMT_WORD 2'h0
`define IFD_FMT_CHAR 2'h1
`define IFD_FMT_BUS 2'h2
`define IFD_FMT_IO 2'h3

// word format
`define IFD_W_A 17
`define IFD_W_B_HI 16
`define IFD_W_B_LO 15
// character format
`define IFD_C_B_HI 18
`define IFD_C_B_LO 17
// business words: first word chars, next two index flags
`define IFD_BUS_SC_HI 13
`define IFD_BUS_SC_LO 8
`define IFD_BUS_DC_HI 7
`define IFD_BUS_DC_LO 0
`define IFD_BUS_F_HI 18
`define IFD_BUS_F_LO 17
// io format
`define IFD_IO_CH_HI 17
`define IFD_IO_CH_LO 15
`define IFD_IO_INT 14
`define IFD_IO_G 13
`define IFD_IO_IN 12

// fields register layout
`define IFD_F_A 0
`define IFD_F_B_LO 1
`define IFD_F_V_LO 3
`define IFD_F_W_LO 9
`define IFD_F_CH_LO 16
`define IFD_F_INT 19
`define IFD_F_G 20
`define IFD_F_FA_LO 21
`define IFD_F_FC_LO 23

`define IFD_RST_WORD 24'h000000
`define IFD_RST_ADDR 17'h00000

`endif

/* core/ifd_addr_conv.v */
// word/character address conversion, purely combinational
// assumes four characters per word, position in the low two bits
`timescale 1ns/100ps
`default_nettype none
module ifd_addr_conv #(
	parameter WAW = 15
) (
	// word address plus position in
	input wire [WAW-1:0] wordAddrIn,
	input wire [1:0] charPosIn,
	// character address in
	input wire [WAW+1:0] charAddrIn,
	// results
	output wire [WAW+1:0] charAddrOut,
	output wire [WAW-1:0] wordAddrOut,
	output wire [1:0] charPosOut
);
	// times four then add position; low bits free so the add is a concat
	assign charAddrOut = {wordAddrIn, charPosIn};
	// divide by four: quotient is word, remainder is position
	assign wordAddrOut = charAddrIn[WAW+1:2];
	assign charPosOut = charAddrIn[1:0];
endmodule // ifd_addr_conv
`default_nettype wire

/* tb/ifd_decoder_monitor.sv */
// checker on the decoder ports: bus answer, fetch order, control pulses
// assumes one clock domain and a bind from the bench top
`timescale 1ns/100ps
`default_nettype none
`include "ifd_defs.vh"
module ifd_decoder_monitor #(
	parameter WAW = 15
) (
	// clock and reset
	input wire clock,
	input wire sys_rst,
	// wishbone
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [5:0] adr_i,
	input wire [31:0] dat_i,
	input wire [3:0] sel_i,
	input wire ack_o,
	// storage and control
	input wire memRd,
	input wire [WAW-1:0] memAddr,
	input wire memAck,
	input wire cpuDispatch,
	input wire business_data_unitStart,
	input wire opTerminate,
	input wire xferDone,
	input wire ioIrqReq
);
	logic [2:0] acks_reg;
	wire wrAck = ack_o && we_i && cyc_i && stb_i;
	wire startWr = wrAck && adr_i == `IFD_OFS_CTRL && sel_i[0] && dat_i[0];
	wire charWr = wrAck && adr_i == `IFD_OFS_CHTEST;
	// fetches since the last decode finished
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			acks_reg <= 3'h0;
		else if (cpuDispatch || business_data_unitStart)
			acks_reg <= 3'h0;
		else if (memAck && acks_reg != 3'h7)
			acks_reg <= acks_reg + 3'h1;
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	AST_ACK_ONE: assert property (ack_o |=> !ack_o) else $error("ack too long");
	AST_ACK_TAKE: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
	AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
	AST_RD_HOLD: assert property (memRd && !memAck |=> memRd && $stable(memAddr))
		else $error("fetch dropped");
	AST_RD_START: assert property ($rose(memRd) |-> $past(startWr) || $past(startWr, 2))
		else $error("fetch without start");
	AST_BUS_THREE: assert property (business_data_unitStart |-> acks_reg == 3'h3)
		else $error("business op not three words");
	AST_DISP_IDLE: assert property (cpuDispatch |-> !memRd && acks_reg != 3'h0)
		else $error("dispatch during fetch");
	AST_DISP_EXCL: assert property (!(cpuDispatch && business_data_unitStart))
		else $error("both dispatches");
	AST_TERM_CAUSE: assert property (opTerminate |-> $past(charWr) || $past(charWr, 2))
		else $error("terminate without char");
	AST_TERM_ONE: assert property (opTerminate |=> !opTerminate) else $error("terminate too long");
	AST_IRQ_CAUSE: assert property (ioIrqReq |-> $past(xferDone)) else $error("stray irq");
	cover property (business_data_unitStart);
	cover property (opTerminate);
	cover property (ioIrqReq);
	cover property (memAck && memRd ##1 memRd);
endmodule // ifd_decoder_monitor
`default_nettype wire

/* tb/ifd_core_storage.sv */
// core storage model answering the fetch port
// assumes memRd held until memAck; latency set by the bench
`timescale 1ns/100ps
`default_nettype none
module ifd_core_storage (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// fetch port
	input wire logic memRd,
	input wire logic [14:0] memAddr,
	output logic [23:0] memData,
	output logic memAck
);
	logic [23:0] mem [0:32767];
	int lat = 0;
	int waitCnt = 0;
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			memAck <= 1'b0;
			memData <= 24'h000000;
			waitCnt <= 0;
		end else if (memRd && !memAck && waitCnt >= lat) begin
			memAck <= 1'b1;
			memData <= mem[memAddr];
			waitCnt <= 0;
		end else begin
			// data not held outside the answer
			memAck <= 1'b0;
			memData <= ~memData;
			waitCnt <= memRd ? waitCnt + 1 : 0;
		end
	end
endmodule // ifd_core_storage
`default_nettype wire

/* tb/ifd_decoder_tb.sv */
// bench for the decoder: table of formats, then hand tests
// assumes the storage model on the fetch port
`timescale 1ns/100ps
`default_nettype none
`include "ifd_defs.vh"
module ifd_decoder_tb;
	typedef struct {logic [3:0] c; logic [23:0] w0; logic [23:0] w1; logic [23:0] w2;
		logic [5:0] ra; logic [16:0] ea; logic [5:0] rb; logic [24:0] mb; logic [24:0] eb;} ifd_row_t;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic xferDone = 1'b0;
	logic [5:0] adr = 6'h00;
	logic [31:0] wdat = 32'h00000000;
	logic [3:0] sel = 4'h0;
	logic [31:0] q;
	wire logic [31:0] rdat;
	wire logic ack, memRd, memAck, disp, bduStart, term, irq, wcc;
	wire logic [14:0] memAddr;
	wire logic [23:0] memData;
	wire logic [2:0] chSel;
	int miscompares = 0;
	int n_tests = 0;
	// unused words zero
	ifd_row_t rows [9] = '{
		'{4'h1, 24'h001234, 24'h0, 24'h0, 6'h18, 17'h01234, 6'h1C, 25'h7, 25'h0},
		'{4'h1, 24'h009234, 24'h0, 24'h0, 6'h18, 17'h01334, 6'h1C, 25'h7, 25'h2},
		'{4'h1, 24'h011234, 24'h0, 24'h0, 6'h18, 17'h01598, 6'h1C, 25'h7, 25'h4},
		'{4'h1, 24'h01FFFF, 24'h0, 24'h0, 6'h18, 17'h00FFF, 6'h1C, 25'h7, 25'h6},
		'{4'h1, 24'h028200, 24'h0, 24'h0, 6'h18, 17'h003A4, 6'h14, 25'hFFFFFF, 25'h028200},
		'{4'h3, 24'h03FFFF, 24'h0, 24'h0, 6'h18, 17'h000FF, 6'h1C, 25'h6, 25'h2},
		'{4'h3, 24'h00ABCD, 24'h0, 24'h0, 6'h18, 17'h0ABCD, 6'h14, 25'hFFFFFF, 25'h00ABCD},
		'{4'hD, 24'h002A55, 24'h060413, 24'h040413, 6'h20, 17'h00513, 6'h24, 25'h1FFFF, 25'h00777},
		'{4'h5, 24'h003F15, 24'h030000, 24'h000005, 6'h20, 17'h10100, 6'h1C, 25'h1E00000, 25'h0200000}};
	always #5 clock = ~clock;
	ifd_decoder i_ifd_decoder (.clock(clock), .sys_rst(sys_rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .dat_i(wdat), .sel_i(sel), .dat_o(rdat), .ack_o(ack), .memRd(memRd),
		.memAddr(memAddr), .memData(memData), .memAck(memAck), .cpuDispatch(disp),
		.business_data_unitStart(bduStart), .opTerminate(term), .xferDone(xferDone),
		.ioIrqReq(irq), .wordCountCtl(wcc), .io_channel_select(chSel));
	ifd_core_storage i_ifd_core_storage (.clock(clock), .sys_rst(sys_rst), .memRd(memRd),
		.memAddr(memAddr), .memData(memData), .memAck(memAck));
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
		int t;
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		t = 0;
		do begin
			@(posedge clock);
			t++;
		end while (ack !== 1'b1 && t < 100);
		if (t == 100)
			miscompares++;
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic rdchk(input string nm, input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
		wb(1'b0, a, 32'h00000000);
		chk(nm, e, q & m);
	endtask
	task automatic waitDone;
		int i;
		q = 32'h00000000;
		for (i = 0; i < 60 && q[`IFD_CTRL_DONE] !== 1'b1; i++)
			wb(1'b0, `IFD_OFS_CTRL, 32'h00000000);
		chk("done", 32'h1, {31'h0, q[`IFD_CTRL_DONE]});
	endtask
	task automatic decode(input logic [3:0] c, input logic [14:0] p, input logic [23:0] w0, w1, w2);
		i_ifd_core_storage.mem[p] = w0;
		i_ifd_core_storage.mem[p + 15'h1] = w1;
		i_ifd_core_storage.mem[p + 15'h2] = w2;
		wb(1'b1, `IFD_OFS_PADDR, {17'h0, p});
		wb(1'b1, `IFD_OFS_CTRL, {28'h0, c});
		waitDone();
	endtask
	task automatic charTest(input logic [31:0] ch, input logic [31:0] e);
		wb(1'b1, `IFD_OFS_CHTEST, ch);
		rdchk("term", `IFD_OFS_CTRL, 32'h400, e);
	endtask
	task automatic results;
		$display("tests %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#300000;
		miscompares++;
		results();
	end
	initial begin
		repeat (12) @(posedge clock);
		sys_rst <= 1'b0;
		i_ifd_core_storage.mem[15'h0300] = 24'h010040;
		rdchk("ctrl", `IFD_OFS_CTRL, 32'hFFFFFFFF, 32'h0);
		rdchk("eaddr", `IFD_OFS_EADDR, 32'hFFFFFFFF, 32'h0);
		rdchk("unmapped", 6'h38, 32'hFFFFFFFF, 32'h0);
		wb(1'b1, `IFD_OFS_IDX1, 32'h00000100);
		wb(1'b1, `IFD_OFS_IDX2, 32'h00000364);
		wb(1'b1, `IFD_OFS_IDX3, 32'h00001000);
		for (int k = 0; k < 9; k++) begin
			i_ifd_core_storage.lat = k % 3;
			decode(rows[k].c, 15'(16 + 4 * k), rows[k].w0, rows[k].w1, rows[k].w2);
			rdchk("first", rows[k].ra, 32'h1FFFF, 32'(rows[k].ea));
			rdchk("second", rows[k].rb, 32'(rows[k].mb), 32'(rows[k].eb));
		end
		rdchk("chars", `IFD_OFS_CHARS, 32'h3FFF, 32'h3F15);
		charTest(32'h16, 32'h0);
		charTest(32'h15, 32'h400);
		decode(4'hD, 15'h0100, 24'h002A55, 24'h060413, 24'h040413);
		rdchk("vw", `IFD_OFS_FIELDS, 32'h0000FFF8, 32'h0000AAA8);
		charTest(32'h15, 32'h0);
		charTest(32'h55, 32'h400);
		wb(1'b1, `IFD_OFS_CHTEST, 32'h0000002A);
		rdchk("hits", `IFD_OFS_CTRL, 32'h00001C00, 32'h00001400);
		wb(1'b1, `IFD_OFS_CONVWA, 32'h00011522);
		rdchk("convwa", `IFD_OFS_CONVWA, 32'h1FFFF, 32'h0000548A);
		wb(1'b1, `IFD_OFS_CONVCA, 32'h00000722);
		rdchk("convca", `IFD_OFS_CONVCA, 32'h1FFFF, 32'h000101C8);
		for (int ch = 0; ch < 8; ch++) begin
			decode(4'h7, 15'h0200, {6'h00, 3'(ch), ch[0], ch[1], 1'b1, 12'h000}, 24'h0, 24'h0);
			chk("chsel", 32'(ch), {29'h0, chSel});
			chk("wcc", {31'h0, ch[1]}, {31'h0, wcc});
			@(posedge clock);
			xferDone <= 1'b1;
			@(posedge clock);
			xferDone <= 1'b0;
			#1;
			chk("irq", {31'h0, ch[0]}, {31'h0, irq});
		end
		// start while busy is ignored
		i_ifd_core_storage.lat = 20;
		wb(1'b1, `IFD_OFS_PADDR, 32'h00000014);
		wb(1'b1, `IFD_OFS_CTRL, 32'h00000001);
		wb(1'b1, `IFD_OFS_CTRL, 32'h00000003);
		waitDone();
		rdchk("busy", `IFD_OFS_EADDR, 32'h1FFFF, 32'h00001334);
		// reset in mid fetch
		wb(1'b1, `IFD_OFS_CTRL, 32'h00000001);
		repeat (3) @(posedge clock);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		chk("memrd", 32'h0, {31'h0, memRd});
		rdchk("ctrl", `IFD_OFS_CTRL, 32'hFFFFFFFF, 32'h0);
		results();
	end
endmodule // ifd_decoder_tb
bind ifd_decoder ifd_decoder_monitor #(.WAW(WAW)) i_ifd_decoder_monitor (.clock(clock), .sys_rst(sys_rst),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .ack_o(ack_o),
	.memRd(memRd), .memAddr(memAddr), .memAck(memAck), .cpuDispatch(cpuDispatch),
	.business_data_unitStart(business_data_unitStart), .opTerminate(opTerminate),
	.xferDone(xferDone), .ioIrqReq(ioIrqReq));
`default_nettype wire
